// ### dvd_pkg.sv
// Function
// - Measure each high phase of sliced data to find data frequency.
// - Manchester: accept single or doubled high time as a match.
// - Observe three periods (three high times, one per period) before deciding validity.
// - Thresholds count the system clock divided by four.
// - Reset: lower threshold zero, upper one; window counter inactive.
// - Six-bit level threshold scales wanted voltage, 1.2 V is 63.
// - Reset: level threshold all ones; level detection inactive.
// - On and off values encode 65535 minus RC oscillator cycles.
// - Valid data during on period pulses the detect line to wake host.
// - Window complete edge latches level compare; combined forms data valid.
// - Continuous or single-shot detection chosen by two bits at 00h.
// - Ready for next conversion three data periods after previous start.
package dvd_pkg;

  localparam logic [7:0]  addr_config      = 8'h00;
  localparam logic [7:0]  addr_on_period   = 8'h04;
  localparam logic [7:0]  addr_off_period  = 8'h05;
  localparam logic [7:0]  addr_lower_th    = 8'h06;
  localparam logic [7:0]  addr_upper_th    = 8'h07;
  localparam logic [7:0]  addr_level_th    = 8'h08;
  localparam logic [7:0]  addr_irq_status  = 8'h10;
  localparam logic [7:0]  addr_irq_mask    = 8'h11;
  localparam logic [7:0]  addr_live_status = 8'h12;

  localparam int unsigned cfg_continuous_bit = 5;
  localparam int unsigned cfg_single_bit     = 6;
  localparam int unsigned cfg_poll_bit       = 0;

  localparam logic [15:0] on_period_reset    = 16'hfebf;
  localparam logic [15:0] off_period_reset   = 16'hf37f;
  localparam logic [11:0] lower_th_reset     = 12'h000;
  localparam logic [11:0] upper_th_reset     = 12'h001;
  localparam logic [5:0]  level_th_reset     = 6'h3f;
  localparam logic [15:0] config_reset       = 16'h0000;

  localparam int unsigned clk_div            = 4;
  localparam int unsigned periods_needed     = 3;
  localparam int unsigned irq_bits           = 3;
  localparam int unsigned irq_valid_bit      = 0;
  localparam int unsigned irq_invalid_bit    = 1;
  localparam int unsigned irq_wake_bit       = 2;

  typedef struct packed {
    logic [11:0] lower;
    logic [11:0] upper;
    logic [5:0]  level;
    logic        continuous;
    logic        single;
  } detect_cfg_t;

  typedef struct packed {
    logic done;
    logic valid;
  } detect_result_t;

endpackage

// ### poll_timer.sv
`timescale 1ns/1ps
module poll_timer (
  input  wire logic        ref_clk,
  input  wire logic        reset,
  input  wire logic        enable,
  input  wire logic        rc_tick,
  input  wire logic [15:0] on_value,
  input  wire logic [15:0] off_value,
  output logic             rx_on
);
  logic [16:0] count_reg;
  logic        rx_on_reg;
  wire         overflow = count_reg[16];

  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      count_reg <= 17'h00000;
      rx_on_reg <= 1'b0;
    end else if (!enable) begin
      // Load one past the value so a phase lasts 65535 minus value ticks
      count_reg <= {1'b0, on_value} + 17'h00001;
      rx_on_reg <= 1'b1;
    end else if (overflow) begin
      count_reg <= {1'b0, rx_on_reg ? off_value : on_value} + 17'h00001;
      rx_on_reg <= !rx_on_reg;
    end else if (rc_tick) begin
      count_reg <= count_reg + 17'h00001;
    end
  end

  assign rx_on = rx_on_reg;

  a_phase_flip: assert property (@(posedge ref_clk) disable iff (reset)
    enable && overflow |=> rx_on_reg != $past(rx_on_reg))
    else $error("Phase did not flip on overflow");
endmodule // poll_timer

// ### window_detect.sv
`timescale 1ns/1ps
module window_detect #(
  parameter int unsigned CW = 12
) (
  input  wire logic                   ref_clk,
  input  wire logic                   reset,
  input  wire logic                   run,
  input  wire logic                   data_in,
  input  wire logic                   level_ok,
  input  wire dvd_pkg::detect_cfg_t   cfg,
  output dvd_pkg::detect_result_t     result
);
  logic [1:0]    div_reg;
  logic [CW:0]   high_reg;
  logic [2:0]    match_reg;
  logic [2:0]    seen_reg;
  logic          data_d_reg;
  logic          done_reg;
  logic          valid_reg;

  wire           div_tick  = (div_reg == 2'(dvd_pkg::clk_div - 1));
  wire           fall      = data_d_reg && !data_in;
  wire [CW:0]    lo1       = {1'b0, cfg.lower};
  wire [CW:0]    hi1       = {1'b0, cfg.upper};
  wire [CW+1:0]  lo2       = {1'b0, cfg.lower, 1'b0};
  wire [CW+1:0]  hi2       = {1'b0, cfg.upper, 1'b0};
  wire           in_single = high_reg >= lo1 && high_reg <= hi1;
  wire           in_double = {1'b0, high_reg} >= lo2 && {1'b0, high_reg} <= hi2;
  // Reset pair of thresholds parks the counter
  wire           parked    = cfg.lower == dvd_pkg::lower_th_reset &&
                             cfg.upper == dvd_pkg::upper_th_reset;
  wire           active    = cfg.upper > cfg.lower && !parked;
  wire           complete  = fall && seen_reg[1:0] == 2'b11;
  wire           win_ok    = (match_reg[1:0] == 2'b11) && (in_single || in_double);

  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      div_reg    <= 2'h0;
      data_d_reg <= 1'b0;
    end else begin
      div_reg    <= div_reg + 2'h1;
      data_d_reg <= data_in;
    end
  end

  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      high_reg <= '0;
    end else if (!data_in) begin
      high_reg <= '0;
    end else if (div_tick && !high_reg[CW]) begin
      high_reg <= high_reg + 1'b1;
    end
  end

  // Three high phases one per period; counter restarts after each decision
  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      seen_reg  <= 3'h0;
      match_reg <= 3'h0;
      done_reg  <= 1'b0;
      valid_reg <= 1'b0;
    end else begin
      done_reg <= 1'b0;
      if (!run || !active) begin
        seen_reg  <= 3'h0;
        match_reg <= 3'h0;
      end else if (complete) begin
        seen_reg  <= 3'h0;
        match_reg <= 3'h0;
        done_reg  <= 1'b1;
        valid_reg <= win_ok && level_ok;
      end else if (fall) begin
        seen_reg  <= {seen_reg[1:0], 1'b1};
        match_reg <= {match_reg[1:0], in_single || in_double};
      end
    end
  end

  assign result.done  = done_reg;
  assign result.valid = valid_reg;

  a_three_phases: assert property (@(posedge ref_clk) disable iff (reset)
    done_reg |-> $past(seen_reg) == 3'h3)
    else $error("Decision without three high phases");

  a_idle_window: assert property (@(posedge ref_clk) disable iff (reset)
    !active |=> !done_reg)
    else $error("Decision while window is inactive");
endmodule // window_detect

// ### data_valid_polling_detect.sv
// Decided for this implementation: the strobed register port.
`timescale 1ns/1ps
module data_valid_polling_detect (
  input  wire logic        ref_clk,
  input  wire logic        reset,
  input  wire logic [7:0]  reg_addr,
  input  wire logic [15:0] reg_wdata,
  input  wire logic        reg_write,
  input  wire logic        reg_read,
  output logic [15:0]      reg_rdata,
  input  wire logic        data_in,
  input  wire logic [5:0]  level_code,
  input  wire logic        level_code_valid,
  input  wire logic        rc_tick,
  input  wire logic        sequencer_ready,
  output logic             powerdown_detect_line,
  output logic             rx_active,
  output logic             data_valid,
  output logic             irq
);
  ////////////////////////////////////////////////////////////////////////////
  logic [15:0] config_reg;
  logic [15:0] on_reg;
  logic [15:0] off_reg;
  logic [11:0] lower_reg;
  logic [11:0] upper_reg;
  logic [5:0]  level_th_reg;
  logic [5:0]  code_reg;
  logic [2:0]  status_reg;
  logic [2:0]  status_next;
  logic [2:0]  mask_reg;
  logic [15:0] rdata_reg;
  logic        pulse_reg;
  logic        shot_done_reg;
  logic        rx_on;

  dvd_pkg::detect_cfg_t    cfg;
  dvd_pkg::detect_result_t res;

  ////////////////////////////////////////////////////////////////////////////
  wire wr_cfg   = reg_write && reg_addr == dvd_pkg::addr_config;
  wire wr_on    = reg_write && reg_addr == dvd_pkg::addr_on_period;
  wire wr_off   = reg_write && reg_addr == dvd_pkg::addr_off_period;
  wire wr_lower = reg_write && reg_addr == dvd_pkg::addr_lower_th;
  wire wr_upper = reg_write && reg_addr == dvd_pkg::addr_upper_th;
  wire wr_level = reg_write && reg_addr == dvd_pkg::addr_level_th;
  wire wr_stat  = reg_write && reg_addr == dvd_pkg::addr_irq_status;
  wire wr_mask  = reg_write && reg_addr == dvd_pkg::addr_irq_mask;

  wire continuous = config_reg[dvd_pkg::cfg_continuous_bit];
  wire single     = config_reg[dvd_pkg::cfg_single_bit];
  wire polling    = config_reg[dvd_pkg::cfg_poll_bit];
  // Single shot stops after one decision until the mode is rewritten
  wire run        = sequencer_ready && rx_on && (continuous || (single && !shot_done_reg));
  // Full-scale code 63 compares to 1.2 V; all-ones threshold never passes
  wire level_ok   = (level_th_reg != dvd_pkg::level_th_reset) && (code_reg >= level_th_reg);
  wire wake       = res.done && res.valid && rx_on;
  wire [2:0] events = {wake, res.done && !res.valid, res.done && res.valid};

  wire [15:0] rd_mux =
    reg_addr == dvd_pkg::addr_config      ? config_reg :
    reg_addr == dvd_pkg::addr_on_period   ? on_reg :
    reg_addr == dvd_pkg::addr_off_period  ? off_reg :
    reg_addr == dvd_pkg::addr_lower_th    ? {4'h0, lower_reg} :
    reg_addr == dvd_pkg::addr_upper_th    ? {4'h0, upper_reg} :
    reg_addr == dvd_pkg::addr_level_th    ? {10'h000, level_th_reg} :
    reg_addr == dvd_pkg::addr_irq_status  ? {13'h0000, status_reg} :
    reg_addr == dvd_pkg::addr_irq_mask    ? {13'h0000, mask_reg} :
    reg_addr == dvd_pkg::addr_live_status ? {12'h000, rx_on, data_valid, pulse_reg, run} :
    16'h0000;

  assign cfg.lower      = lower_reg;
  assign cfg.upper      = upper_reg;
  assign cfg.level      = level_th_reg;
  assign cfg.continuous = continuous;
  assign cfg.single     = single;
  // Set wins over a clear in the same cycle
  assign status_next    = (wr_stat ? status_reg & ~reg_wdata[2:0] : status_reg) | events;

  ////////////////////////////////////////////////////////////////////////////
  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      config_reg   <= dvd_pkg::config_reset;
      on_reg       <= dvd_pkg::on_period_reset;
      off_reg      <= dvd_pkg::off_period_reset;
      lower_reg    <= dvd_pkg::lower_th_reset;
      upper_reg    <= dvd_pkg::upper_th_reset;
      level_th_reg <= dvd_pkg::level_th_reset;
      mask_reg     <= 3'h0;
    end else begin
      if (wr_cfg)   config_reg   <= reg_wdata;
      if (wr_on)    on_reg       <= reg_wdata;
      if (wr_off)   off_reg      <= reg_wdata;
      if (wr_lower) lower_reg    <= reg_wdata[11:0];
      if (wr_upper) upper_reg    <= reg_wdata[11:0];
      if (wr_level) level_th_reg <= reg_wdata[5:0];
      if (wr_mask)  mask_reg     <= reg_wdata[2:0];
    end
  end

  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      status_reg    <= 3'h0;
      rdata_reg     <= 16'h0000;
      pulse_reg     <= 1'b0;
      shot_done_reg <= 1'b0;
      code_reg      <= 6'h00;
    end else begin
      status_reg <= status_next;
      rdata_reg  <= reg_read ? rd_mux : 16'h0000;
      pulse_reg  <= wake;
      if (level_code_valid) code_reg <= level_code;
      // A decision beside a config write still uses up the shot
      if (res.done) shot_done_reg <= 1'b1;
      else if (wr_cfg) shot_done_reg <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  window_detect #(
    .CW (12)
  ) u_window (
    .ref_clk  (ref_clk),
    .reset    (reset),
    .run      (run),
    .data_in  (data_in),
    .level_ok (level_ok),
    .cfg      (cfg),
    .result   (res)
  );

  poll_timer u_timer (
    .ref_clk   (ref_clk),
    .reset     (reset),
    .enable    (polling),
    .rc_tick   (rc_tick),
    .on_value  (on_reg),
    .off_value (off_reg),
    .rx_on     (rx_on)
  );

  assign reg_rdata             = rdata_reg;
  assign powerdown_detect_line = pulse_reg;
  assign rx_active             = rx_on;
  assign data_valid            = res.valid;
  assign irq                   = |(status_reg & mask_reg);

  ////////////////////////////////////////////////////////////////////////////
  sequence s_wake;
    res.done && res.valid && rx_on;
  endsequence

  sequence s_invalid;
    res.done && !res.valid;
  endsequence

  sequence s_any_event;
    |events;
  endsequence

  a_wake_pulse: assert property (@(posedge ref_clk) disable iff (reset)
    s_wake |=> powerdown_detect_line)
    else $error("Wake pulse missing after valid data");

  a_no_stray_pulse: assert property (@(posedge ref_clk) disable iff (reset)
    powerdown_detect_line |-> $past(res.valid) && $past(rx_on))
    else $error("Wake pulse without valid data");

  a_level_write: assert property (@(posedge ref_clk) disable iff (reset)
    wr_level |=> level_th_reg == $past(reg_wdata[5:0]))
    else $error("Level threshold not stored");

  a_lower_write: assert property (@(posedge ref_clk) disable iff (reset)
    wr_lower |=> lower_reg == $past(reg_wdata[11:0]))
    else $error("Lower threshold not stored");

  a_on_write: assert property (@(posedge ref_clk) disable iff (reset)
    wr_on |=> on_reg == $past(reg_wdata))
    else $error("On period not stored");

  a_mode_gate: assert property (@(posedge ref_clk) disable iff (reset)
    !continuous && !single |-> !run)
    else $error("Detection runs with no mode");

  a_level_gate: assert property (@(posedge ref_clk) disable iff (reset)
    level_th_reg == 6'h3f |-> !level_ok)
    else $error("Level detection active at all ones");

  a_valid_level: assert property (@(posedge ref_clk) disable iff (reset)
    res.done && res.valid |-> $past(level_ok))
    else $error("Valid without level pass");

  a_upper_write: assert property (@(posedge ref_clk) disable iff (reset)
    wr_upper |=> upper_reg == $past(reg_wdata[11:0]))
    else $error("Upper threshold not stored");

  a_off_write: assert property (@(posedge ref_clk) disable iff (reset)
    wr_off |=> off_reg == $past(reg_wdata))
    else $error("Off period not stored");

  a_cfg_write: assert property (@(posedge ref_clk) disable iff (reset)
    wr_cfg |=> config_reg == $past(reg_wdata))
    else $error("Config not stored");

  a_mask_write: assert property (@(posedge ref_clk) disable iff (reset)
    wr_mask |=> mask_reg == $past(reg_wdata[2:0]))
    else $error("Mask not stored");

  a_on_hold: assert property (@(posedge ref_clk) disable iff (reset)
    !wr_on |=> $stable(on_reg))
    else $error("On period changed without write");

  a_off_hold: assert property (@(posedge ref_clk) disable iff (reset)
    !wr_off |=> $stable(off_reg))
    else $error("Off period changed without write");

  a_lower_hold: assert property (@(posedge ref_clk) disable iff (reset)
    !wr_lower |=> $stable(lower_reg))
    else $error("Lower threshold changed without write");

  a_upper_hold: assert property (@(posedge ref_clk) disable iff (reset)
    !wr_upper |=> $stable(upper_reg))
    else $error("Upper threshold changed without write");

  a_level_hold: assert property (@(posedge ref_clk) disable iff (reset)
    !wr_level |=> $stable(level_th_reg))
    else $error("Level threshold changed without write");

  a_rdata_idle: assert property (@(posedge ref_clk) disable iff (reset)
    !reg_read |=> reg_rdata == 16'h0000)
    else $error("Read data outside read slot");

  a_rdata_read: assert property (@(posedge ref_clk) disable iff (reset)
    reg_read |=> reg_rdata == $past(rd_mux))
    else $error("Read data not the addressed register");

  a_pulse_single: assert property (@(posedge ref_clk) disable iff (reset)
    powerdown_detect_line |=> !powerdown_detect_line)
    else $error("Wake pulse longer than one cycle");

  a_pulse_done: assert property (@(posedge ref_clk) disable iff (reset)
    powerdown_detect_line |-> $past(res.done))
    else $error("Wake pulse without decision");

  a_done_single: assert property (@(posedge ref_clk) disable iff (reset)
    res.done |=> !res.done)
    else $error("Decision strobe longer than one cycle");

  a_done_run: assert property (@(posedge ref_clk) disable iff (reset)
    res.done |-> $past(run))
    else $error("Decision while detection stopped");

  a_valid_change: assert property (@(posedge ref_clk) disable iff (reset)
    $changed(res.valid) |-> res.done)
    else $error("Valid changed outside a decision");

  a_status_set: assert property (@(posedge ref_clk) disable iff (reset)
    s_any_event |=> (status_reg & $past(events)) == $past(events))
    else $error("Event not recorded in status");

  a_status_clear: assert property (@(posedge ref_clk) disable iff (reset)
    wr_stat && !(|events) |=> (status_reg & $past(reg_wdata[2:0])) == 3'h0)
    else $error("Status bit not cleared by write of one");

  a_status_sticky: assert property (@(posedge ref_clk) disable iff (reset)
    !wr_stat |=> (status_reg & $past(status_reg)) == $past(status_reg))
    else $error("Status bit lost without clear");

  a_wake_status: assert property (@(posedge ref_clk) disable iff (reset)
    s_wake |=> status_reg[dvd_pkg::irq_wake_bit])
    else $error("Wake event not recorded");

  a_invalid_status: assert property (@(posedge ref_clk) disable iff (reset)
    s_invalid |=> status_reg[dvd_pkg::irq_invalid_bit])
    else $error("Invalid decision not recorded");

  a_single_stop: assert property (@(posedge ref_clk) disable iff (reset)
    !continuous && shot_done_reg |-> !run)
    else $error("Single shot runs after its decision");

  a_shot_set: assert property (@(posedge ref_clk) disable iff (reset)
    res.done |=> shot_done_reg)
    else $error("Shot not marked used");

  a_shot_rearm: assert property (@(posedge ref_clk) disable iff (reset)
    wr_cfg && !res.done |=> !shot_done_reg)
    else $error("Config write did not rearm single shot");

  a_run_rx_on: assert property (@(posedge ref_clk) disable iff (reset)
    run |-> rx_on)
    else $error("Detection runs in off phase");

  a_run_sequencer: assert property (@(posedge ref_clk) disable iff (reset)
    run |-> sequencer_ready)
    else $error("Detection runs before sequencer allows");

  a_code_latch: assert property (@(posedge ref_clk) disable iff (reset)
    level_code_valid |=> code_reg == $past(level_code))
    else $error("Level code not latched");

  a_level_pass: assert property (@(posedge ref_clk) disable iff (reset)
    level_ok |-> code_reg >= level_th_reg)
    else $error("Level pass below threshold");

  a_rx_idle_on: assert property (@(posedge ref_clk) disable iff (reset)
    !polling |=> rx_on)
    else $error("Receiver off with polling disabled");
endmodule // data_valid_polling_detect

// ### host_wake_model.sv
`timescale 1ns/1ps
module host_wake_model (
  input  wire logic ref_clk,
  input  wire logic reset,
  input  wire logic powerdown_detect_line,
  output int        wake_count
);
  // One wake per high cycle, so a stuck line shows up as extra wakes
  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      wake_count <= 0;
    end else if (powerdown_detect_line) begin
      wake_count <= wake_count + 1;
    end
  end
endmodule // host_wake_model

// ### data_valid_polling_detect_tb_top.sv
`timescale 1ns/1ps
module data_valid_polling_detect_tb_top;
  logic        ref_clk          = 1'b0;
  logic        reset            = 1'b1;
  logic [7:0]  reg_addr         = 8'h00;
  logic [15:0] reg_wdata        = 16'h0000;
  logic        reg_write        = 1'b0;
  logic        reg_read         = 1'b0;
  logic [15:0] reg_rdata;
  logic        data_in          = 1'b0;
  logic [5:0]  level_code       = 6'h00;
  logic        level_code_valid = 1'b0;
  logic        rc_tick          = 1'b0;
  logic        sequencer_ready  = 1'b1;
  logic        powerdown_detect_line;
  logic        rx_active;
  logic        data_valid;
  logic        irq;
  int          wake_count;
  int          mismatches       = 0;
  int          cmp_count        = 0;
  int          tick_div         = 0;
  int          n;
  logic [7:0]  ad [8] = '{8'h04, 8'h05, 8'h06, 8'h07, 8'h08, 8'h10, 8'h11, 8'h03};
  logic [15:0] rv [8] = '{16'hfebf, 16'hf37f, 16'h0000, 16'h0001, 16'h003f, 16'h0000,
                          16'h0000, 16'h0000};
  logic [15:0] ev [8] = '{16'h1234, 16'habcd, 16'h0fff, 16'h0fff, 16'h003f, 16'h0000,
                          16'h0007, 16'h0000};
  //////////////////////////////////////////////////////////////////////////////////////
  always #2.5 ref_clk = ~ref_clk;
  always @(posedge ref_clk) begin
    tick_div <= (tick_div + 1) % 4;
    rc_tick  <= (tick_div == 3);
  end
  data_valid_polling_detect data_valid_polling_detect_i (
    .ref_clk(ref_clk), .reset(reset), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_write(reg_write), .reg_read(reg_read), .reg_rdata(reg_rdata),
    .data_in(data_in), .level_code(level_code), .level_code_valid(level_code_valid),
    .rc_tick(rc_tick), .sequencer_ready(sequencer_ready),
    .powerdown_detect_line(powerdown_detect_line), .rx_active(rx_active),
    .data_valid(data_valid), .irq(irq));
  host_wake_model host_wake_model_i (
    .ref_clk(ref_clk), .reset(reset),
    .powerdown_detect_line(powerdown_detect_line), .wake_count(wake_count));
  //////////////////////////////////////////////////////////////////////////////////////
  task report_and_stop();
    $display("counts: cmp_count=%0d mismatches=%0d", cmp_count, mismatches);
    if (mismatches == 0 && cmp_count > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask
  task check(input logic [15:0] got, input logic [15:0] exp);
    cmp_count++;
    if (got !== exp) begin
      mismatches++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task reg_wr(input logic [7:0] a, input logic [15:0] d);
    @(posedge ref_clk);
    reg_addr  <= a;
    reg_wdata <= d;
    reg_write <= 1'b1;
    @(posedge ref_clk);
    reg_write <= 1'b0;
  endtask
  // Read data stand only in the cycle after the strobe
  task reg_chk(input logic [7:0] a, input logic [15:0] e);
    @(posedge ref_clk);
    reg_addr <= a;
    reg_read <= 1'b1;
    @(posedge ref_clk);
    reg_read <= 1'b0;
    @(negedge ref_clk);
    check(reg_rdata, e);
  endtask
  task detect(input logic [15:0] cfg, input int hi, input int reps, input logic [5:0] lvl,
              input logic [15:0] st, input logic dv, input int wakes);
    n = wake_count;
    reg_wr(dvd_pkg::addr_irq_status, 16'h0007);
    reg_wr(dvd_pkg::addr_config, 16'h0000);
    reg_wr(dvd_pkg::addr_config, cfg);
    @(posedge ref_clk);
    level_code       <= lvl;
    level_code_valid <= 1'b1;
    @(posedge ref_clk);
    level_code_valid <= 1'b0;
    repeat (reps) begin
      data_in <= 1'b1;
      repeat (hi) @(posedge ref_clk);
      data_in <= 1'b0;
      repeat (hi) @(posedge ref_clk);
    end
    repeat (8) @(posedge ref_clk);
    reg_chk(dvd_pkg::addr_irq_status, st);
    check(16'(data_valid), 16'(dv));
    check(16'(wake_count - n), 16'(wakes));
    $display("test detect cfg=%h hi=%0d done", cfg, hi);
  endtask
  // Ticks counted in one receive phase; the phase must also end in bounded time
  task phase_ticks(input logic lvl, input int exp);
    int c;
    int i;
    c = 0;
    for (i = 0; i < 3000 && rx_active !== lvl; i++) @(posedge ref_clk);
    for (i = 0; i < 3000 && rx_active === lvl; i++) begin
      @(posedge ref_clk);
      if (rc_tick === 1'b1 && rx_active === lvl) c++;
    end
    if (i >= 3000) begin
      mismatches++;
      report_and_stop();
    end
    check(16'(c), 16'(exp));
  endtask
  //////////////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (2) @(posedge ref_clk);
    reset <= 1'b0;
    for (int i = 0; i < 8; i++) reg_chk(ad[i], rv[i]);
    detect(16'h0020, 40, 4, 6'h20, 16'h0000, 1'b0, 0);
    for (int i = 0; i < 8; i++) begin
      reg_wr(ad[i], ev[i] | 16'hffff & {16{i > 1}} | ev[i]);
      reg_chk(ad[i], ev[i]);
    end
    $display("test registers done");
    // Window 8..12 divided counts, a 40 cycle high time sits mid-window
    reg_wr(dvd_pkg::addr_lower_th, 16'h0008);
    reg_wr(dvd_pkg::addr_upper_th, 16'h000c);
    reg_wr(dvd_pkg::addr_level_th, 16'h0010);
    reg_wr(dvd_pkg::addr_irq_mask, 16'h0000);
    detect(16'h0020, 40, 4, 6'h20, 16'h0005, 1'b1, 1);
    detect(16'h0020, 80, 4, 6'h20, 16'h0005, 1'b1, 1);
    detect(16'h0020, 60, 4, 6'h20, 16'h0002, 1'b0, 0);
    detect(16'h0020, 40, 4, 6'h05, 16'h0002, 1'b0, 0);
    @(posedge ref_clk);
    sequencer_ready <= 1'b0;
    detect(16'h0020, 40, 4, 6'h20, 16'h0000, 1'b0, 0);
    @(posedge ref_clk);
    sequencer_ready <= 1'b1;
    detect(16'h0020, 40, 7, 6'h20, 16'h0005, 1'b1, 2);
    detect(16'h0040, 40, 7, 6'h20, 16'h0005, 1'b1, 1);
    check(16'(irq), 16'h0000);
    reg_wr(dvd_pkg::addr_irq_mask, 16'h0001);
    repeat (2) @(negedge ref_clk);
    check(16'(irq), 16'h0001);
    reg_wr(dvd_pkg::addr_irq_status, 16'h0001);
    repeat (2) @(negedge ref_clk);
    check(16'(irq), 16'h0000);
    reg_chk(dvd_pkg::addr_irq_status, 16'h0004);
    reg_chk(dvd_pkg::addr_live_status, 16'h000c);
    $display("test interrupt done");
    reg_wr(dvd_pkg::addr_on_period, 16'hfff0);
    reg_wr(dvd_pkg::addr_off_period, 16'hffe0);
    reg_wr(dvd_pkg::addr_config, 16'h0021);
    phase_ticks(1'b0, 31);
    phase_ticks(1'b1, 15);
    $display("test polling timer done");
    report_and_stop();
  end
endmodule // data_valid_polling_detect_tb_top
